// ==== src/vid_monitor_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the voltage-ID monitor.
`ifndef VID_MONITOR_REGS_SVH
`define VID_MONITOR_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_READ_2V5       8'h20
`define OFS_READ_PROCESSOR_CORE_VOLTAGE      8'h21
`define OFS_READ_VCC       8'h22
`define OFS_READ_5V        8'h23
`define OFS_READ_12V       8'h24
`define OFS_CONFIG_ONE     8'h40
`define OFS_STATUS_TWO     8'h42
`define OFS_VID_CODE       8'h43
`define OFS_LOW_12V        8'h4c
`define OFS_HIGH_12V       8'h4d
`define OFS_CONFIG_TWO     8'h73
`define OFS_MASK_TWO       8'h75

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_PIN_SELECT     7
`define BIT_VID_THRESHOLD  6
`define BIT_SIXTH_VID      5
`define BIT_SUPPLY_FLAG    0
`define BIT_MASK_CHANGE    0
`define BIT_AVG_OFF        4
`define BIT_VCC_5V         7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_LOW_LIMIT      8'h00
`define RST_HIGH_LIMIT     8'hff
`define RST_CONFIG         8'h00
`define RST_READING        10'h000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      100
`define VID_TICK_NS        11000
`define VID_TICK_CYCLES    (`VID_TICK_NS / `CLK_PERIOD_NS)
`define CONV_TIME_NS       711000
`define CONV_CYCLES        (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define AVG_COUNT          16
`define CHAN_12V           3'h4
`define CHAN_LAST_5VID     3'h3

`endif

// ==== src/vid_monitor_pkg.sv ====
// Types shared by the voltage-ID monitor modules.
package vid_monitor_pkg;
   typedef logic [2:0] chan_t;
   typedef logic [9:0] code_t;
   typedef enum logic [0:0] {CONV_WAIT, CONV_BUSY} conv_phase_t;
endpackage

// ==== src/conv_if.sv ====
// Conversion hand-off between the sequencer and the averaging engine.
`timescale 1ns/1ps
interface conv_if;
   logic                    done;
   vid_monitor_pkg::code_t  code;
   logic                    res_valid;
   vid_monitor_pkg::code_t  res_code;
   modport seq (output done, output code, input res_valid, input res_code);
   modport avg (input done, input code, output res_valid, output res_code);
endinterface

// ==== src/conv_averager.sv ====
// Averaging engine: turns single conversions into value-register results.
`timescale 1ns/1ps
`include "vid_monitor_regs.svh"
module conv_averager
(
   // Clock and reset.
   input  wire logic  i_clk,
   input  wire logic  i_rst,
   // Mode.
   input  wire logic  i_avg_off,
   // Conversion link.
   conv_if.avg        cv
);
   logic [3:0]  cnt_r;
   logic [13:0] sum_r;
   logic [13:0] sum_nxt;

   assign sum_nxt = sum_r + {4'h0, cv.code};

   // Unless averaging is off, sixteen conversions are summed and only the finished mean is published.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_r        <= 4'h0;
         sum_r        <= 14'h0000;
         cv.res_valid <= 1'b0;
         cv.res_code  <= `RST_READING;
      end
      else
      begin
         cv.res_valid <= 1'b0;
         if (cv.done)
         begin
            if (i_avg_off)
            begin
               cv.res_valid <= 1'b1; // [RULE10]
               cv.res_code  <= cv.code;
               cnt_r        <= 4'h0;
               sum_r        <= 14'h0000;
            end
            else if (cnt_r == 4'(`AVG_COUNT - 1))
            begin
               cv.res_valid <= 1'b1; // [RULE9]
               cv.res_code  <= sum_nxt[13:4];
               cnt_r        <= 4'h0;
               sum_r        <= 14'h0000;
            end
            else
            begin
               cnt_r <= cnt_r + 4'h1;
               sum_r <= sum_nxt;
            end
         end
      end
   end

   a_avg_after_sixteen: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE9]
      (cv.done && !i_avg_off && cnt_r != 4'hf) |=> !cv.res_valid)
      else $error("Averaged result published before sixteen conversions.");
   a_single_result: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE10]
      (cv.done && i_avg_off) |=> (cv.res_valid && cv.res_code == $past(cv.code)))
      else $error("Averaging off did not pass the single conversion.");
   c_avg_result: cover property (@(posedge i_clk) disable iff (i_rst) cv.res_valid && !i_avg_off);
endmodule // conv_averager

// ==== src/voltage_id_monitor.sv ====
// Voltage-ID monitor with shared-pin select, code-change detect and voltage readout.
//
// Functional notes
// [RULE1] Select bit picks 12 V input or sixth ID
// [RULE2] Sixth ID bit reads zero in 12 V mode
// [RULE3] Sixth ID bit follows shared pin when selected
// [RULE4] Status bit flags 12 V limit violation
// [RULE5] Status bit flags code change in six-input mode
// [RULE6] No 12 V monitoring while pin is ID
// [RULE7] Change flag set on difference over 11 us
// [RULE8] Unmasked code change raises the alert
// [RULE9] Readings hold average of sixteen conversions
// [RULE10] Averaging off publishes each single conversion
// [RULE11] Results are 10-bit codes, nominal 768
// [RULE12] 5 V supply mode rescales supply channel
// [RULE13] Low ID bits mirror the five pins
// [RULE14] Alert released after read once condition gone
// [RULE15] Sample ID inputs on fixed 11 us tick
// [RULE16] Change flag held until read, zero otherwise
`timescale 1ns/1ps
`include "vid_monitor_regs.svh"
module voltage_id_monitor
#(
   parameter int CONV_CYCLES = `CONV_CYCLES
)
(
   // Clock and reset.
   input  wire logic                     i_clk,
   input  wire logic                     i_rst,
   // Register port, transactions already decoded by the bus engine.
   input  wire logic [7:0]               i_reg_addr,
   input  wire logic                     i_reg_wr,
   input  wire logic [7:0]               i_reg_wdata,
   input  wire logic                     i_reg_rd,
   output logic      [7:0]               o_reg_rdata,
   // Alert response address answered.
   input  wire logic                     i_ara_ack,
   // Voltage-ID and shared pins.
   input  wire logic [4:0]               i_vid_pins,
   input  wire logic                     i_shared_pin,
   // Converter.
   output logic                          o_conv_start,
   output vid_monitor_pkg::chan_t        o_conv_chan,
   input  wire logic                     i_conv_done,
   input  wire vid_monitor_pkg::code_t   i_conv_code,
   // Analog front-end controls.
   output logic                          o_shared_pin_analog,
   output logic                          o_vcc_5v_scale,
   output logic                          o_vid_threshold_low,
   // Open-drain alert.
   output logic                          o_alert_out,
   output logic                          o_alert_oe_n
);
   localparam int TICK_CYCLES = `VID_TICK_CYCLES;
   localparam int CONV_W      = $clog2(CONV_CYCLES + 1);

   // ----------------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------------
   logic                         shared_pin_function_select_r;
   logic                         vid_threshold_r;
   logic [7:0]                   config_one_r;
   logic [7:0]                   config_two_r;
   logic [7:0]                   mask_two_r;
   logic [7:0]                   low_12v_r;
   logic [7:0]                   high_12v_r;
   vid_monitor_pkg::code_t       reading_r [5];
   logic [7:0]                   rdata_nxt;
   logic                         status_rd;

   assign status_rd = i_reg_rd && (i_reg_addr == `OFS_STATUS_TWO);

   // Software writes; only writable fields are kept.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         shared_pin_function_select_r <= 1'b0;
         vid_threshold_r              <= 1'b0;
         config_one_r                 <= `RST_CONFIG;
         config_two_r                 <= `RST_CONFIG;
         mask_two_r                   <= `RST_CONFIG;
         low_12v_r                    <= `RST_LOW_LIMIT;
         high_12v_r                   <= `RST_HIGH_LIMIT;
      end
      else if (i_reg_wr)
      begin
         unique case (i_reg_addr)
            `OFS_VID_CODE:
            begin
               shared_pin_function_select_r <= i_reg_wdata[`BIT_PIN_SELECT]; // [RULE1]
               vid_threshold_r              <= i_reg_wdata[`BIT_VID_THRESHOLD];
            end
            `OFS_CONFIG_ONE: config_one_r <= i_reg_wdata;
            `OFS_CONFIG_TWO: config_two_r <= i_reg_wdata;
            `OFS_MASK_TWO:   mask_two_r   <= i_reg_wdata;
            `OFS_LOW_12V:    low_12v_r    <= i_reg_wdata;
            `OFS_HIGH_12V:   high_12v_r   <= i_reg_wdata;
            default:         ;
         endcase
      end
   end

   // Front-end controls come straight from register flops.
   assign o_shared_pin_analog = !shared_pin_function_select_r; // [RULE1]
   assign o_vcc_5v_scale      = config_one_r[`BIT_VCC_5V]; // [RULE12]
   assign o_vid_threshold_low = vid_threshold_r;

   // ----------------------------------------------------------------------------
   // Voltage-ID sampling and change detect
   // ----------------------------------------------------------------------------
   logic [5:0]  vid_now;
   logic [5:0]  vid_sample_r;
   logic [5:0]  vid_prev_r;
   logic [7:0]  tick_cnt_r;
   logic        tick;
   logic        code_changed;
   logic        vc_flag_r;

   // The sixth bit is forced low in 12 V mode so an analog level cannot look like a code.
   assign vid_now = {shared_pin_function_select_r & i_shared_pin, i_vid_pins}; // [RULE2] [RULE3] [RULE13]
   assign tick    = (tick_cnt_r == 8'(TICK_CYCLES - 1));

   // Free-running tick; the comparison window is the tick period.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         tick_cnt_r <= 8'h00;
      else if (tick)
         tick_cnt_r <= 8'h00; // [RULE15]
      else
         tick_cnt_r <= tick_cnt_r + 8'h01;
   end

   // Pins are taken as synchronous, so one register stage gives a stable sample.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         vid_sample_r <= 6'h00;
         vid_prev_r   <= 6'h00;
      end
      else
      begin
         vid_sample_r <= vid_now;
         if (tick)
            vid_prev_r <= vid_sample_r; // [RULE15]
      end
   end

   assign code_changed = tick && (vid_sample_r != vid_prev_r) && shared_pin_function_select_r; // [RULE7]

   // Change flag: a new change wins over the read that would clear it.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         vc_flag_r <= 1'b0;
      else if (!shared_pin_function_select_r)
         vc_flag_r <= 1'b0; // [RULE16]
      else if (code_changed)
         vc_flag_r <= 1'b1; // [RULE7]
      else if (status_rd)
         vc_flag_r <= 1'b0; // [RULE16]
   end

   // ----------------------------------------------------------------------------
   // Conversion sequencing
   // ----------------------------------------------------------------------------
   conv_if cv ();
   vid_monitor_pkg::conv_phase_t  phase_r;
   vid_monitor_pkg::chan_t        chan_r;
   logic [CONV_W-1:0]             conv_cnt_r;
   logic                          conv_due;

   assign cv.done     = i_conv_done && (phase_r == vid_monitor_pkg::CONV_BUSY);
   assign cv.code     = i_conv_code;
   assign conv_due    = (conv_cnt_r == CONV_W'(CONV_CYCLES - 1));
   assign o_conv_start = conv_due && (phase_r == vid_monitor_pkg::CONV_WAIT);
   assign o_conv_chan = chan_r;

   // One conversion per slot; a slow converter simply stretches the slot.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         phase_r    <= vid_monitor_pkg::CONV_WAIT;
         conv_cnt_r <= '0;
      end
      else
      begin
         if (!conv_due)
            conv_cnt_r <= conv_cnt_r + CONV_W'(1);
         else if (phase_r == vid_monitor_pkg::CONV_WAIT)
            conv_cnt_r <= '0;
         unique case (phase_r)
            vid_monitor_pkg::CONV_WAIT: if (o_conv_start) phase_r <= vid_monitor_pkg::CONV_BUSY;
            vid_monitor_pkg::CONV_BUSY: if (i_conv_done) phase_r <= vid_monitor_pkg::CONV_WAIT;
         endcase
      end
   end

   // Channel advances only after a finished result; the 12 V slot is skipped in ID mode.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         chan_r <= 3'h0;
      else if (cv.res_valid)
      begin
         if (chan_r == `CHAN_12V)
            chan_r <= 3'h0;
         else if (chan_r == `CHAN_LAST_5VID && shared_pin_function_select_r)
            chan_r <= 3'h0; // [RULE6]
         else
            chan_r <= chan_r + 3'h1;
      end
   end

   conv_averager u_avg
   (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_avg_off  (config_two_r[`BIT_AVG_OFF]),
      .cv         (cv.avg)
   );

   // Value registers keep the full 10-bit code; the read port returns the upper byte.
   genvar g;
   generate
      for (g = 0; g < 5; g++)
      begin : g_reading
         always_ff @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
               reading_r[g] <= `RST_READING;
            else if (cv.res_valid && chan_r == 3'(g))
               reading_r[g] <= cv.res_code; // [RULE11]
         end
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // 12 V limit check
   // ----------------------------------------------------------------------------
   logic        lim12_now_r;
   logic        lim12_flag_r;
   logic        lim12_event;
   logic        lim12_out;

   assign lim12_out   = (cv.res_code[9:2] < low_12v_r) || (cv.res_code[9:2] > high_12v_r);
   assign lim12_event = cv.res_valid && (chan_r == `CHAN_12V) && !shared_pin_function_select_r && lim12_out;

   // Present-state tracker lets the sticky flag survive a read while still out of range.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         lim12_now_r <= 1'b0;
      else if (shared_pin_function_select_r)
         lim12_now_r <= 1'b0; // [RULE6]
      else if (cv.res_valid && chan_r == `CHAN_12V)
         lim12_now_r <= lim12_out; // [RULE4]
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         lim12_flag_r <= 1'b0;
      else if (shared_pin_function_select_r)
         lim12_flag_r <= 1'b0; // [RULE5]
      else if (lim12_event || lim12_now_r)
         lim12_flag_r <= 1'b1; // [RULE4]
      else if (status_rd)
         lim12_flag_r <= 1'b0;
   end

   // ----------------------------------------------------------------------------
   // Status bit and alert
   // ----------------------------------------------------------------------------
   logic        supply_or_code_change_flag;
   logic        alert_r;
   logic        ara_seen_r;
   logic        alert_cause;

   assign supply_or_code_change_flag = shared_pin_function_select_r ? vc_flag_r : lim12_flag_r; // [RULE4] [RULE5]
   assign alert_cause = supply_or_code_change_flag && !mask_two_r[`BIT_MASK_CHANGE]; // [RULE8]

   // The host must answer the alert response first; a status read alone keeps the line low.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         ara_seen_r <= 1'b0;
      else if (i_ara_ack)
         ara_seen_r <= 1'b1;
      else if (status_rd)
         ara_seen_r <= 1'b0;
   end

   // Release is tested first: the flag is still set in the cycle of the clearing read.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         alert_r <= 1'b0;
      else if (status_rd && ara_seen_r && !code_changed && !lim12_event && !lim12_now_r)
         alert_r <= 1'b0; // [RULE14]
      else if (alert_cause)
         alert_r <= 1'b1; // [RULE8]
   end

   assign o_alert_out  = 1'b0;
   assign o_alert_oe_n = !alert_r;

   // ----------------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------------
   always_comb
   begin
      rdata_nxt = 8'h00;
      unique case (i_reg_addr)
         `OFS_READ_2V5:   rdata_nxt = reading_r[0][9:2];
         `OFS_READ_PROCESSOR_CORE_VOLTAGE:  rdata_nxt = reading_r[1][9:2];
         `OFS_READ_VCC:   rdata_nxt = reading_r[2][9:2];
         `OFS_READ_5V:    rdata_nxt = reading_r[3][9:2];
         `OFS_READ_12V:   rdata_nxt = reading_r[4][9:2];
         `OFS_CONFIG_ONE: rdata_nxt = config_one_r;
         `OFS_STATUS_TWO: rdata_nxt = {7'h00, supply_or_code_change_flag};
         `OFS_VID_CODE:   rdata_nxt = {shared_pin_function_select_r, vid_threshold_r, vid_sample_r};
         `OFS_LOW_12V:    rdata_nxt = low_12v_r;
         `OFS_HIGH_12V:   rdata_nxt = high_12v_r;
         `OFS_CONFIG_TWO: rdata_nxt = config_two_r;
         `OFS_MASK_TWO:   rdata_nxt = mask_two_r;
         default:         rdata_nxt = 8'h00;
      endcase
   end

   // Read data is captured on the strobe and held until the next read.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd)
         o_reg_rdata <= rdata_nxt;
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_sixth_bit_zero: assert property ( // [RULE2]
      (i_reg_rd && i_reg_addr == `OFS_VID_CODE && !shared_pin_function_select_r && $past(!shared_pin_function_select_r))
      |=> !o_reg_rdata[5])
      else $error("Sixth ID bit not zero in 12 V mode.");
   a_sixth_bit_pin: assert property ( // [RULE3]
      (i_reg_rd && i_reg_addr == `OFS_VID_CODE && shared_pin_function_select_r && $past(shared_pin_function_select_r))
      |=> o_reg_rdata[5] == $past(i_shared_pin, 2))
      else $error("Sixth ID bit does not follow the shared pin.");
   a_low_bits_pins: assert property ( // [RULE13]
      (i_reg_rd && i_reg_addr == `OFS_VID_CODE) |=> o_reg_rdata[4:0] == $past(i_vid_pins, 2))
      else $error("Low ID bits do not mirror the pins.");
   a_status_12v: assert property ( // [RULE4]
      (status_rd && !shared_pin_function_select_r) |=> o_reg_rdata[0] == $past(lim12_flag_r))
      else $error("Status bit does not show the 12 V limit flag.");
   a_no_12v_check: assert property ( // [RULE6]
      shared_pin_function_select_r |=> !lim12_flag_r && !lim12_now_r)
      else $error("12 V monitored while pin is an ID input.");
   a_change_sets: assert property ( // [RULE7]
      code_changed |=> vc_flag_r && supply_or_code_change_flag)
      else $error("Code change did not set the flag.");
   a_change_forced: assert property ( // [RULE16]
      !shared_pin_function_select_r |=> !vc_flag_r)
      else $error("Change flag set in 12 V mode.");
   a_tick_period: assert property ( // [RULE15]
      tick |=> (!tick)[*8] ##102 tick)
      else $error("Sampling tick period wrong.");
   a_alert_masked: assert property ( // [RULE8]
      (mask_two_r[0] && !alert_r && !(i_reg_wr && i_reg_addr == `OFS_MASK_TWO)) |=> !alert_r)
      else $error("Masked flag drove the alert.");
   a_alert_raise: assert property ( // [RULE8]
      (alert_cause && !(status_rd && ara_seen_r)) |=> !o_alert_oe_n)
      else $error("Unmasked flag did not raise the alert.");
   a_alert_hold: assert property ( // [RULE14]
      (alert_r && !ara_seen_r && !i_ara_ack) |=> alert_r)
      else $error("Alert released without alert response.");

   c_code_change: cover property (code_changed);
   c_alert_release: cover property (alert_r ##1 !alert_r);
   c_limit_12v: cover property (lim12_event);
endmodule // voltage_id_monitor

// ==== test/conv_partner.sv ====
// Converter model that answers each start after a short or a long wait.
`timescale 1ns/1ps
module conv_partner
(
   // Clock and reset.
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   // Converter link.
   input  wire logic               i_start,
   input  wire logic               i_dither,
   output logic                    o_done,
   output vid_monitor_pkg::code_t  o_code
);
   int    wait_r;
   logic  slow_r;

   // Prompt and slow answers alternate, so both slot cases are exercised.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         wait_r <= 0;
      else if (i_start)
         wait_r <= slow_r ? 30 : 2;
      else if (wait_r > 0)
         wait_r <= wait_r - 1;
   end

   // Pace and dither sign flip after every answer.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         slow_r <= 1'b0;
      else if (o_done)
         slow_r <= ~slow_r;
   end

   // Dithered codes average to 768 only over an even count; idle lines show the inverse.
   assign o_done = (wait_r == 1);
   assign o_code = !o_done ? 10'h0ff : (!i_dither ? 10'h300 : (slow_r ? 10'h308 : 10'h2f8));
endmodule // conv_partner

// ==== test/voltage_id_monitor_bench.sv ====
// Self-checking bench for the voltage-ID monitor.
`timescale 1ns/1ps
module voltage_id_monitor_bench;
   logic                    clk;
   logic                    rst;
   logic [7:0]              addr;
   logic                    wr;
   logic [7:0]              wdata;
   logic                    rd;
   logic [7:0]              rdata;
   logic                    ara;
   logic [4:0]              pins;
   logic                    shared;
   logic                    start;
   vid_monitor_pkg::chan_t  chan;
   logic                    done;
   vid_monitor_pkg::code_t  code;
   logic                    dither;
   logic                    analog;
   logic                    scale;
   logic                    oe_n;
   logic                    thld;
   logic                    adata;
   int                      failures;
   int                      total_checks;

   // A short slot keeps the averaged runs brief.
   voltage_id_monitor #(.CONV_CYCLES(20)) i_voltage_id_monitor (.i_clk(clk), .i_rst(rst),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_ara_ack(ara), .i_vid_pins(pins), .i_shared_pin(shared), .o_conv_start(start),
      .o_conv_chan(chan), .i_conv_done(done), .i_conv_code(code), .o_shared_pin_analog(analog),
      .o_vcc_5v_scale(scale), .o_vid_threshold_low(thld), .o_alert_out(adata), .o_alert_oe_n(oe_n));
   conv_partner i_conv_partner (.i_clk(clk), .i_rst(rst), .i_start(start), .i_dither(dither),
      .o_done(done), .o_code(code));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Inputs always move one nanosecond after the rising edge.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // An idle edge follows each strobe, so the next one never rises in the same step.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(1);
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input bit chk = 1'b1);
      addr = a;
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      if (chk)
         check(rdata, exp);
      step(1);
   endtask

   // The host answers the alert and reads the status once.
   task automatic release_alert();
      ara = 1'b1;
      step(1);
      ara = 1'b0;
      step(1);
      rd_reg(8'h42, 8'h00, 1'b0);
   endtask

   task automatic s_reset();
      check({7'h0, oe_n}, 8'h01);
      check({7'h0, analog}, 8'h01);
      rd_reg(8'h43, 8'h15);
      rd_reg(8'h42, 8'h00);
      rd_reg(8'h30, 8'h00);
   endtask

   task automatic s_avg_off_limit();
      wr_reg(8'h73, 8'h10);
      step(400);
      rd_reg(8'h24, 8'hc0);
      wr_reg(8'h4d, 8'hbf);
      step(400);
      rd_reg(8'h42, 8'h01);
      check({6'h0, adata, oe_n}, 8'h00);
      wr_reg(8'h4d, 8'hff);
      step(400);
      release_alert();
      rd_reg(8'h42, 8'h00);
      check({7'h0, oe_n}, 8'h01);
   endtask

   task automatic s_select_change();
      pins = 5'h0a;
      step(250);
      rd_reg(8'h42, 8'h00);
      wr_reg(8'h43, 8'h80);
      check({7'h0, analog}, 8'h00);
      rd_reg(8'h43, 8'haa);
      step(250);
      release_alert();
      rd_reg(8'h42, 8'h00);
      check({7'h0, oe_n}, 8'h01);
      pins = 5'h0b;
      step(250);
      rd_reg(8'h42, 8'h01);
      check({7'h0, oe_n}, 8'h00);
      release_alert();
      rd_reg(8'h42, 8'h00);
      check({7'h0, oe_n}, 8'h01);
   endtask

   task automatic s_mask();
      wr_reg(8'h43, 8'hc0);
      check({6'h0, analog, thld}, 8'h01);
      wr_reg(8'h75, 8'h01);
      shared = 1'b0;
      step(250);
      rd_reg(8'h42, 8'h01);
      check({7'h0, oe_n}, 8'h01);
      wr_reg(8'h75, 8'h00);
   endtask

   task automatic s_avg_on();
      dither = 1'b1;
      wr_reg(8'h40, 8'h80);
      check({7'h0, scale}, 8'h01);
      wr_reg(8'h73, 8'h00);
      step(4000);
      rd_reg(8'h22, 8'hc0);
      rd_reg(8'h20, 8'hc0);
   endtask

   // The twelve-volt channel must never be converted while the pin is an ID input; this is checked only while dither is set.
   // Start is combinational, so it is looked at on the falling edge where it has settled.
   always @(negedge clk)
      if (start && !analog && dither)
         check({7'h0, chan == 3'h4}, 8'h00);

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      rst = 1'b1;
      {addr, wr, wdata, rd, ara, dither} = '0;
      pins = 5'h15;
      shared = 1'b1;
      failures = 0;
      total_checks = 0;
      step(20);
      rst = 1'b0;
      step(1);
      s_reset();
      s_avg_off_limit();
      s_select_change();
      s_mask();
      s_avg_on();
      end_of_test();
   end

   // Watchdog well beyond the roughly six thousand three hundred cycles the run needs.
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      end_of_test();
   end
endmodule // voltage_id_monitor_bench
